// File: hw/dsrc_top.sv
// disable and restart state control for limit evaluation, ir remote and feedback sends
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
module dsrc_top
	import dsrc_pkg::*;
#(
	parameter int SEC_CYC   = DSRC_SEC_CYC,
	parameter int FLASH_CYC = DSRC_FLASH_CYC
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                clk_en,
	input  wire dsrc_pkg::dsrc_apb_req_t apb_req,
	output logic                     pready,
	output logic                     pslverr,
	output logic [31:0]              prdata,
	output dsrc_pkg::dsrc_ctl_t      ctl
);
	import dsrc_pkg::*;

	initial begin
		if (SEC_CYC < 1 || FLASH_CYC < 1) begin
			$error("dsrc_top: cycle counts must be at least one");
		end
	end

	typedef struct packed {
		logic [15:0] cfg;
		logic [5:0]  dly_min;
		logic [5:0]  dly_sec;
		logic [15:0] cfg_limit;
		logic [15:0] ext_limit;
		logic        ext_valid;
		logic        blv_dis;
		logic        ir_dis;
		logic        blv_dis_saved;
		logic        ir_dis_saved;
		logic        fb1_on;
		logic        fb1_auto;
		logic        fb1_off;
		logic        walk_test;
		logic [31:0] flash_cnt;
		logic        led;
		logic [31:0] sec_cnt;
		logic [12:0] dly_left;
		dsrc_state_t st;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic [3:0]  ir_acc;
	} dsrc_reg_t;

	dsrc_reg_t s_r;
	dsrc_reg_t s_nxt;

	logic        wr_acc;
	logic        wr_do;
	logic        rd_acc;
	logic [31:0] wd;
	logic        cmd;
	logic [15:0] eff_limit;
	dsrc_ir_t    irc;
	logic        ir_ok;

	assign wr_acc = apb_req.psel && !apb_req.penable && apb_req.pwrite;
	assign rd_acc = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
	// writes land at the edge where the master sees ready, never in setup
	assign wr_do  = apb_req.psel && apb_req.penable && apb_req.pwrite && s_r.pready;
	assign wd     = apb_req.pwdata;
	assign cmd    = wr_do && apb_req.paddr == DSRC_OFF_CMD;
	// external value wins once preset or teach has taken one, until teach-in or a download with overwrite clears it
	assign eff_limit = s_r.ext_valid ? s_r.ext_limit : s_r.cfg_limit;
	assign irc       = dsrc_ir_t'(wd[3:0]);
	assign ir_ok     = s_r.cfg[DSRC_CFG_IR_EN] && !s_r.ir_dis;

	always_comb begin
		s_nxt = s_r;
		// no wait state: answer in the first access phase cycle after setup
		s_nxt.pready  = apb_req.psel && !apb_req.penable;
		s_nxt.pslverr = 1'b0;
		if (rd_acc) begin
			unique case (apb_req.paddr)
				DSRC_OFF_CFG:    s_nxt.prdata = {16'h0000, s_r.cfg};
				DSRC_OFF_DELAY:  s_nxt.prdata = {18'h00000, s_r.dly_min, 2'h0, s_r.dly_sec};
				DSRC_OFF_STATUS: s_nxt.prdata = {21'h000000, s_r.st, s_r.led, s_r.walk_test,
						s_r.fb1_off, s_r.fb1_auto, s_r.fb1_on, s_r.ir_dis, s_r.blv_dis, s_r.ext_valid};
				DSRC_OFF_LIMIT:  s_nxt.prdata = {eff_limit, s_r.cfg_limit};
				DSRC_OFF_CMD,
				DSRC_OFF_IRCMD:  s_nxt.prdata = DSRC_ERR_DATA;
				default: begin
					s_nxt.prdata  = DSRC_ERR_DATA;
					s_nxt.pslverr = 1'b1;
				end
			endcase
		end
		if (wr_acc) begin
			unique case (apb_req.paddr)
				DSRC_OFF_CFG,
				DSRC_OFF_DELAY,
				DSRC_OFF_LIMIT,
				DSRC_OFF_CMD,
				DSRC_OFF_IRCMD,
				DSRC_OFF_STATUS: s_nxt.pslverr = 1'b0;
				default: s_nxt.pslverr = 1'b1;
			endcase
		end
		if (wr_do) begin
			unique case (apb_req.paddr)
				DSRC_OFF_CFG: s_nxt.cfg = wd[15:0];
				DSRC_OFF_DELAY: begin
					// out of range values clamp to 59
					s_nxt.dly_sec = (wd[5:0] > DSRC_DLY_MAX) ? DSRC_DLY_MAX : wd[5:0];
					s_nxt.dly_min = (wd[13:8] > DSRC_DLY_MAX) ? DSRC_DLY_MAX : wd[13:8];
				end
				DSRC_OFF_LIMIT: s_nxt.cfg_limit = wd[15:0];
				default: begin
				end
			endcase
		end

		// limit and ir disable telegrams: polarity selectable, feature optional
		if (cmd && wd[DSRC_CMD_BLV_TEL] && s_r.cfg[DSRC_CFG_BLV_DIS_USE]) begin
			s_nxt.blv_dis = wd[DSRC_CMD_BLV_VAL] ^ s_r.cfg[DSRC_CFG_BLV_POL];
		end
		if (cmd && wd[DSRC_CMD_IR_TEL] && s_r.cfg[DSRC_CFG_IR_DIS_USE]) begin
			s_nxt.ir_dis = wd[DSRC_CMD_IR_VAL] ^ s_r.cfg[DSRC_CFG_IR_POL];
		end

		// preset and teach ignore the disable state
		if (cmd && wd[DSRC_CMD_PRESET]) begin
			s_nxt.ext_limit = wd[31:16];
			s_nxt.ext_valid = 1'b1;
		end
		if (cmd && wd[DSRC_CMD_TEACH]) begin
			s_nxt.ext_limit = wd[31:16];
			s_nxt.ext_valid = 1'b1;
		end
		if (cmd && wd[DSRC_CMD_TEACH_IN]) begin
			s_nxt.ext_valid = 1'b0;
		end

		// bus failure: save disable states, external limit untouched
		if (cmd && wd[DSRC_CMD_BUS_FAIL]) begin
			s_nxt.blv_dis_saved = s_r.blv_dis;
			s_nxt.ir_dis_saved  = s_r.ir_dis;
			s_nxt.st            = DSRC_ST_DOWN;
		end

		// bus return
		if (cmd && wd[DSRC_CMD_BUS_RET]) begin
			unique case (dsrc_ret_t'(s_r.cfg[DSRC_CFG_BLV_BUS_LO +: 2]))
				DSRC_RET_OFF:  s_nxt.blv_dis = 1'b0;
				DSRC_RET_ON:   s_nxt.blv_dis = 1'b1;
				DSRC_RET_PREV: s_nxt.blv_dis = s_r.blv_dis_saved;
				default:       s_nxt.blv_dis = 1'b0;
			endcase
			unique case (dsrc_ret_t'(s_r.cfg[DSRC_CFG_IR_BUS_LO +: 2]))
				DSRC_RET_OFF:  s_nxt.ir_dis = 1'b0;
				DSRC_RET_ON:   s_nxt.ir_dis = 1'b1;
				DSRC_RET_PREV: s_nxt.ir_dis = s_r.ir_dis_saved;
				default:       s_nxt.ir_dis = 1'b0;
			endcase
			if (!s_r.cfg[DSRC_CFG_BLV_DIS_USE]) begin
				s_nxt.blv_dis = 1'b0;
			end
			if (!s_r.cfg[DSRC_CFG_IR_DIS_USE]) begin
				s_nxt.ir_dis = 1'b0;
			end
			// delay in seconds; only the automatic feedback sends wait on it
			s_nxt.dly_left = 13'(s_r.dly_min * DSRC_SEC_PER_MIN) + 13'(s_r.dly_sec);
			s_nxt.sec_cnt  = 32'h0000_0000;
			s_nxt.st       = (s_nxt.dly_left == 13'h0000) ? DSRC_ST_RUN : DSRC_ST_WAIT;
		end

		// download wins over a return in the same write
		if (cmd && wd[DSRC_CMD_DOWNLOAD]) begin
			if (s_r.cfg[DSRC_CFG_OVERWRITE]) begin
				s_nxt.ext_valid = 1'b0;
			end
			// without overwrite the external value simply stays
			s_nxt.blv_dis = s_r.cfg[DSRC_CFG_BLV_DIS_USE] && s_r.cfg[DSRC_CFG_BLV_PROG];
			s_nxt.ir_dis  = s_r.cfg[DSRC_CFG_IR_DIS_USE] && s_r.cfg[DSRC_CFG_IR_PROG];
			s_nxt.st       = DSRC_ST_RUN;
			s_nxt.dly_left = 13'h0000;
		end

		// return delay countdown in whole seconds
		if (s_r.st == DSRC_ST_WAIT) begin
			if (s_r.sec_cnt >= 32'(SEC_CYC - 1)) begin
				s_nxt.sec_cnt  = 32'h0000_0000;
				s_nxt.dly_left = s_r.dly_left - 13'h0001;
				if (s_r.dly_left == 13'h0001) begin
					s_nxt.st = DSRC_ST_RUN;
				end
			end else begin
				s_nxt.sec_cnt = s_r.sec_cnt + 32'h0000_0001;
			end
		end

		// infrared commands, function block one only
		s_nxt.ir_acc = 4'h0;
		if (wr_do && apb_req.paddr == DSRC_OFF_IRCMD && ir_ok) begin
			if (irc.on && s_r.cfg[DSRC_CFG_BTN_ON]) begin
				s_nxt.fb1_on   = 1'b1;
				s_nxt.fb1_auto = 1'b0;
				s_nxt.fb1_off  = 1'b0;
				s_nxt.ir_acc[0] = 1'b1;
			end else if (irc.auto_mode && s_r.cfg[DSRC_CFG_BTN_AUTO]) begin
				s_nxt.fb1_on   = 1'b0;
				s_nxt.fb1_auto = 1'b1;
				s_nxt.fb1_off  = 1'b0;
				s_nxt.ir_acc[1] = 1'b1;
			end else if (irc.off && s_r.cfg[DSRC_CFG_BTN_OFF]) begin
				s_nxt.fb1_on   = 1'b0;
				s_nxt.fb1_auto = 1'b0;
				s_nxt.fb1_off  = 1'b1;
				s_nxt.ir_acc[2] = 1'b1;
			end else if (irc.test && s_r.cfg[DSRC_CFG_BTN_TEST]) begin
				s_nxt.walk_test = !s_r.walk_test;
				s_nxt.ir_acc[3] = 1'b1;
			end
		end
		// led flash restarts on every accepted command
		if (|s_nxt.ir_acc) begin
			s_nxt.led       = 1'b1;
			s_nxt.flash_cnt = 32'(FLASH_CYC - 1);
		end else if (s_r.led) begin
			if (s_r.flash_cnt == 32'h0000_0000) begin
				s_nxt.led = 1'b0;
			end else begin
				s_nxt.flash_cnt = s_r.flash_cnt - 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r        <= '0;
			s_r.cfg    <= DSRC_CFG_RST;
			s_r.st     <= DSRC_ST_RUN;
			s_r.prdata <= DSRC_ERR_DATA;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	logic [15:0] ctl_limit_r;
	logic        ctl_eval_r;
	logic        ctl_send_r;
	logic        ctl_use_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_limit_r <= 16'h0000;
			ctl_eval_r  <= 1'b0;
			ctl_send_r  <= 1'b0;
			ctl_use_r   <= 1'b1;
		end else if (clk_en) begin
			ctl_use_r   <= !s_nxt.ext_valid;
			ctl_limit_r <= s_nxt.ext_valid ? s_nxt.ext_limit : s_nxt.cfg_limit;
			ctl_eval_r  <= !s_nxt.blv_dis && s_nxt.st != DSRC_ST_DOWN;
			ctl_send_r  <= s_nxt.st == DSRC_ST_RUN;
		end
	end

	assign pready  = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign prdata  = s_r.prdata;
	assign ctl.blv_eval_en = ctl_eval_r;
	assign ctl.blv_use_cfg = ctl_use_r;
	assign ctl.blv_limit   = ctl_limit_r;
	assign ctl.fb1_on      = s_r.fb1_on;
	assign ctl.fb1_auto    = s_r.fb1_auto;
	assign ctl.fb1_off     = s_r.fb1_off;
	assign ctl.walk_test   = s_r.walk_test;
	assign ctl.led_blue    = s_r.led;
	assign ctl.fb_send_en  = ctl_send_r;
endmodule // dsrc_top

// File: hw/dsrc_pkg.sv
// package: constants and carrier types for the disable and restart state control
package dsrc_pkg;
	// register byte offsets
	localparam logic [7:0] DSRC_OFF_CFG     = 8'h00;
	localparam logic [7:0] DSRC_OFF_DELAY   = 8'h04;
	localparam logic [7:0] DSRC_OFF_CMD     = 8'h08;
	localparam logic [7:0] DSRC_OFF_STATUS  = 8'h0C;
	localparam logic [7:0] DSRC_OFF_LIMIT   = 8'h10;
	localparam logic [7:0] DSRC_OFF_IRCMD   = 8'h14;
	// config field positions
	localparam int DSRC_CFG_OVERWRITE   = 0;
	localparam int DSRC_CFG_BLV_DIS_USE = 1;
	localparam int DSRC_CFG_BLV_POL     = 2;
	localparam int DSRC_CFG_BLV_BUS_LO  = 3;
	localparam int DSRC_CFG_BLV_PROG    = 5;
	localparam int DSRC_CFG_IR_EN       = 6;
	localparam int DSRC_CFG_IR_DIS_USE  = 7;
	localparam int DSRC_CFG_IR_POL      = 8;
	localparam int DSRC_CFG_IR_BUS_LO   = 9;
	localparam int DSRC_CFG_IR_PROG     = 11;
	localparam int DSRC_CFG_BTN_ON      = 12;
	localparam int DSRC_CFG_BTN_AUTO    = 13;
	localparam int DSRC_CFG_BTN_OFF     = 14;
	localparam int DSRC_CFG_BTN_TEST    = 15;
	localparam int DSRC_CFG_W           = 16;
	localparam logic [15:0] DSRC_CFG_RST = 16'h0000;
	// command register bits (write one to act; DSRC_CMD_BLV_VAL and DSRC_CMD_IR_VAL carry the telegram value)
	localparam int DSRC_CMD_DOWNLOAD = 0;
	localparam int DSRC_CMD_BUS_FAIL = 1;
	localparam int DSRC_CMD_BUS_RET  = 2;
	localparam int DSRC_CMD_BLV_TEL  = 3;
	localparam int DSRC_CMD_BLV_VAL  = 4;
	localparam int DSRC_CMD_IR_TEL   = 5;
	localparam int DSRC_CMD_IR_VAL   = 6;
	localparam int DSRC_CMD_PRESET   = 7;
	localparam int DSRC_CMD_TEACH    = 8;
	localparam int DSRC_CMD_TEACH_IN = 9;
	// delay fields
	localparam int DSRC_DLY_SEC_LSB = 0;
	localparam int DSRC_DLY_MIN_LSB = 8;
	localparam logic [5:0] DSRC_DLY_MAX = 6'h3B;
	// timing
	localparam int DSRC_CLK_HZ      = 20000000;
	localparam int DSRC_SEC_CYC     = DSRC_CLK_HZ;
	localparam int DSRC_SEC_PER_MIN = 60;
	localparam int DSRC_FLASH_MS    = 100;
	localparam int DSRC_FLASH_CYC   = DSRC_CLK_HZ / 1000 * DSRC_FLASH_MS;
	localparam logic [31:0] DSRC_ERR_DATA = 32'h0000_0000;

	// bus-return disable settings
	typedef enum logic [1:0] {
		DSRC_RET_OFF  = 2'h0,
		DSRC_RET_ON   = 2'h1,
		DSRC_RET_PREV = 2'h2
	} dsrc_ret_t;

	// ir command code: one-hot buttons
	typedef struct packed {
		logic test;
		logic off;
		logic auto_mode;
		logic on;
	} dsrc_ir_t;

	// apb request carrier
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} dsrc_apb_req_t;

	// outputs toward the rest of the device
	typedef struct packed {
		logic       blv_eval_en;
		logic       blv_use_cfg;
		logic [15:0] blv_limit;
		logic       fb1_on;
		logic       fb1_auto;
		logic       fb1_off;
		logic       walk_test;
		logic       led_blue;
		logic       fb_send_en;
	} dsrc_ctl_t;

	typedef enum logic [2:0] {
		DSRC_ST_RUN  = 3'b001,
		DSRC_ST_DOWN = 3'b010,
		DSRC_ST_WAIT = 3'b100
	} dsrc_state_t;
endpackage

// File: verification/dsrc_top_sva.sv
// checker for the disable and restart state control ports
`timescale 1ns/1ps
module dsrc_top_sva #(
	parameter int FLASH_CYC = 4
) (
	input wire logic                    pclk,
	input wire logic                    presetn,
	input wire logic                    clk_en,
	input wire dsrc_pkg::dsrc_apb_req_t apb_req,
	input wire logic                    pready,
	input wire logic                    pslverr,
	input wire logic [31:0]             prdata,
	input wire dsrc_pkg::dsrc_ctl_t     ctl
);
	import dsrc_pkg::*;
	logic       ir_wr;
	logic [7:0] run_r;
	assign ir_wr = pready && apb_req.pwrite && apb_req.paddr == DSRC_OFF_IRCMD;
	// length of the current blue flash, retriggers only lengthen it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			run_r <= 8'h00;
		else
			run_r <= ctl.led_blue ? run_r + 8'h01 : 8'h00;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ready; (apb_req.psel && !apb_req.penable && clk_en) |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");
	property p_ready_one; (pready && clk_en) |=> !pready; endproperty
	a_ready_one: assert property (p_ready_one) else $error("ready stood two cycles");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_err_data; (pslverr && !apb_req.pwrite) |-> prdata == DSRC_ERR_DATA; endproperty
	a_err_data: assert property (p_err_data) else $error("refused read returned data");
	property p_on; $rose(ctl.fb1_on) |-> $past(ir_wr); endproperty
	a_on: assert property (p_on) else $error("block one mode set without ir command");
	property p_led; $rose(ctl.led_blue) |-> $past(ir_wr); endproperty
	a_led: assert property (p_led) else $error("flash without ir command");
	property p_led_len; $fell(ctl.led_blue) |-> run_r >= FLASH_CYC; endproperty
	a_led_len: assert property (p_led_len) else $error("flash too short");
	property p_limit; $changed(ctl.blv_limit) |-> $past(pready && apb_req.pwrite); endproperty
	a_limit: assert property (p_limit) else $error("limit changed without a write");
endmodule // dsrc_top_sva

bind dsrc_top dsrc_top_sva #(.FLASH_CYC(FLASH_CYC)) dsrc_top_sva_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
	.apb_req(apb_req), .pready(pready), .pslverr(pslverr), .prdata(prdata), .ctl(ctl));

// File: verification/dsrc_apb_mst.sv
// apb master model standing for the bus and configuration side
`timescale 1ns/1ps
module dsrc_apb_mst (
	input  wire logic                pclk,
	input  wire logic                pready,
	input  wire logic                pslverr,
	input  wire logic [31:0]         prdata,
	output dsrc_pkg::dsrc_apb_req_t  req
);
	import dsrc_pkg::*;
	logic err;
	logic tmo;
	int   n;
	initial req = '0;
	// telegrams and commissioning actions arrive as register writes
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge pclk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		tmo = (n >= 50);
		q = prdata;
		err = pslverr;
		req <= '0;
		// let the outputs updated on the ready edge settle before callers look
		@(posedge pclk);
		@(negedge pclk);
	endtask
endmodule // dsrc_apb_mst

// File: verification/testbench.sv
// self-checking bench for the disable and restart state control
`timescale 1ns/1ps
module testbench;
	import dsrc_pkg::*;
	typedef struct {logic [15:0] cfg; logic [3:0] cmd; logic [4:0] exp;} dsrc_row_t;
	logic          pclk, presetn, clk_en, pready, pslverr;
	logic [31:0]   prdata, q;
	dsrc_apb_req_t apb_req;
	dsrc_ctl_t     ctl;
	int            failures, total_checks, n;
	// expect {led, walk, off, auto, on}
	dsrc_row_t rows[11] = '{'{16'h0000, 4'h1, 5'h00}, '{16'hF040, 4'h3, 5'h11}, '{16'hF040, 4'h2, 5'h12},
		'{16'hF040, 4'h4, 5'h14}, '{16'hF040, 4'h8, 5'h1C}, '{16'hF040, 4'h8, 5'h14}, '{16'h7040, 4'h8, 5'h04},
		'{16'hE040, 4'h1, 5'h04}, '{16'hD040, 4'h2, 5'h04}, '{16'hF040, 4'h1, 5'h11}, '{16'hB040, 4'h4, 5'h01}};
	dsrc_top #(.SEC_CYC(10), .FLASH_CYC(4)) dsrc_top_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.apb_req(apb_req), .pready(pready), .pslverr(pslverr), .prdata(prdata), .ctl(ctl));
	dsrc_apb_mst dsrc_apb_mst_i (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .req(apb_req));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	task give_verdict;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
		dsrc_apb_mst_i.xfer(w, a, d, q);
		if (dsrc_apb_mst_i.tmo !== 1'b0) begin
			failures++;
			give_verdict();
		end
	endtask
	initial begin
		presetn = 1'b0;
		clk_en = 1'b1;
		repeat (10) @(posedge pclk);
		chk({ctl.blv_eval_en, ctl.fb_send_en, pready}, 3'b000);
		presetn <= 1'b1;
		@(posedge pclk);
		@(negedge pclk);
		chk({ctl.blv_eval_en, ctl.fb_send_en}, 2'b11);
		xf(1'b0, DSRC_OFF_CFG, 32'h0);
		chk(q, 32'h0);
		xf(1'b0, 8'h18, 32'h0);
		chk({dsrc_apb_mst_i.err, q}, {1'b1, 32'h0});
		foreach (rows[i]) begin
			xf(1'b1, DSRC_OFF_CFG, {16'h0, rows[i].cfg});
			xf(1'b1, DSRC_OFF_IRCMD, {28'h0, rows[i].cmd});
			chk({ctl.led_blue, ctl.walk_test, ctl.fb1_off, ctl.fb1_auto, ctl.fb1_on}, rows[i].exp);
		end
		xf(1'b1, DSRC_OFF_CFG, 32'hF0C0);
		xf(1'b1, DSRC_OFF_CMD, 32'h60);
		xf(1'b1, DSRC_OFF_IRCMD, 32'h2);
		chk({ctl.led_blue, ctl.fb1_auto, ctl.fb1_on}, 3'b001);
		xf(1'b1, DSRC_OFF_CFG, 32'h6);
		xf(1'b1, DSRC_OFF_CMD, 32'h18);
		chk(ctl.blv_eval_en, 1'b1);
		xf(1'b1, DSRC_OFF_CFG, 32'h2);
		xf(1'b1, DSRC_OFF_LIMIT, 32'h1234);
		chk(ctl.blv_limit, 16'h1234);
		xf(1'b1, DSRC_OFF_CMD, 32'h18);
		chk(ctl.blv_eval_en, 1'b0);
		xf(1'b1, DSRC_OFF_CMD, 32'h0ABC_0080);
		chk(ctl.blv_limit, 16'h0ABC);
		xf(1'b1, DSRC_OFF_CMD, 32'h1);
		chk({ctl.blv_eval_en, ctl.blv_limit}, {1'b1, 16'h0ABC});
		xf(1'b1, DSRC_OFF_CFG, 32'h23);
		xf(1'b1, DSRC_OFF_CMD, 32'h1);
		chk({ctl.blv_eval_en, ctl.blv_limit}, {1'b0, 16'h1234});
		xf(1'b1, DSRC_OFF_DELAY, 32'h3F3F);
		xf(1'b0, DSRC_OFF_DELAY, 32'h0);
		chk(q, 32'h3B3B);
		xf(1'b1, DSRC_OFF_DELAY, 32'h2);
		xf(1'b1, DSRC_OFF_CFG, 32'hA);
		xf(1'b1, DSRC_OFF_CMD, 32'h0555_0080);
		xf(1'b1, DSRC_OFF_CMD, 32'h2);
		xf(1'b1, DSRC_OFF_CMD, 32'h4);
		chk({ctl.blv_eval_en, ctl.fb_send_en, ctl.blv_limit}, {2'b00, 16'h0555});
		n = 0;
		while (ctl.fb_send_en !== 1'b1 && n < 100) begin
			@(negedge pclk);
			n++;
		end
		chk(n inside {[15:21]}, 1'b1);
		xf(1'b1, DSRC_OFF_CMD, 32'h4);
		xf(1'b1, DSRC_OFF_CMD, 32'h1);
		chk(ctl.fb_send_en, 1'b1);
		give_verdict();
	end
endmodule // testbench
